// *** hdl/oblp_defs.svh ***
// Named constants for the outbound local packet port.
// Assumes a 20 MHz local clock and a forwarded link clock sampled by it.
`ifndef OBLP_DEFS_SVH
`define OBLP_DEFS_SVH

`define OB_MCLK_PERIOD_NS 50
`define OB_FWD_CLK_PERIOD_NS 400
`define OB_CAP_DELAY_CYC ((`OB_FWD_CLK_PERIOD_NS / 4) / `OB_MCLK_PERIOD_NS)
`define OB_CPL_HOLD_NS 200
`define OB_CPL_HOLD_CYC ((`OB_CPL_HOLD_NS + `OB_MCLK_PERIOD_NS - 1) / `OB_MCLK_PERIOD_NS)

`define OB_BUF_AW 4
`define OB_BUF_DEPTH 5'h10
`define OB_RDY_MARGIN 5'h04

`define OB_HDR_TYPE 27:24
`define OB_HDR_LBE 23:20
`define OB_HDR_FBE 19:16
`define OB_HDR_STAT 17:16
`define OB_HDR_VC 12
`define OB_HDR_LEN 9:0
`define OB_LEN_MAX 11'h400

// request type codes are shared by both directions.
`define OB_TYPE_RD32 4'h0
`define OB_TYPE_RD64 4'h1
`define OB_TYPE_WR32 4'h2
`define OB_TYPE_WR64 4'h3
`define OB_TYPE_CPL 4'h4
`define OB_TYPE_CPLD 4'h5

`define OB_STAT_OK 2'h0
`define OB_STAT_UR 2'h1
`define OB_STAT_CA 2'h2
`define OB_STAT_CTO 2'h3

// window hit codes carried in inbound request address words
`define OB_HIT_WIN0 2'h0
`define OB_HIT_WIN1 2'h1
`define OB_HIT_ROM 2'h2
`define OB_HIT_RSVD 2'h3
// low address bits carry no byte address
`define OB_ADDR_MASK 32'hFFFFFFFC

`define OB_REG_CTRL 8'h00
`define OB_REG_STATUS 8'h04
`define OB_REG_PKTS 8'h08
`define OB_REG_HDR 8'h0C
`define OB_REG_ADDR 8'h10
`define OB_REG_LEVEL 8'h14

`define OB_CTRL_EN 0
`define OB_CTRL_CPL_HOLD 1
`define OB_CTRL_WR_HOLD0 2
`define OB_CTRL_RST 4'h1

`define OB_ST_UNEXP 0
`define OB_ST_MALF 1
`define OB_ST_OVFL 2
`define OB_ST_BADEND 3
`define OB_ST_CPLERR 4

`endif

// *** hdl/oblp_pkg.sv ***
// Types shared by the outbound local packet port and its buffer memory.
// Assumes the constants of oblp_defs.svh.
package oblp_pkg;

  typedef enum logic [1:0] {
    OBLP_P_IDLE = 2'h0,
    OBLP_P_BODY = 2'h1,
    OBLP_P_DROP = 2'h3
  } oblp_pstate_t;

  typedef struct packed {
    logic eop;
    logic bad;
    logic [31:0] data;
  } oblp_entry_t;

endpackage

// *** hdl/oblp_mem_if.sv ***
// Port bundle between the packet port and its word buffer memory.
// Assumes both ends run on the same local clock.
`timescale 1ns/1ps
`include "oblp_defs.svh"

interface oblp_mem_if;
  logic we;
  logic [`OB_BUF_AW-1:0] waddr;
  oblp_pkg::oblp_entry_t wdata;
  logic re;
  logic [`OB_BUF_AW-1:0] raddr;
  oblp_pkg::oblp_entry_t rdata;

  modport ctl (output we, output waddr, output wdata, output re, output raddr, input rdata);
  modport mem (input we, input waddr, input wdata, input re, input raddr, output rdata);
endinterface

// *** hdl/oblp_buf_mem.sv ***
// Word buffer of the outbound packet port, registered read.
// Assumes one write and one read port driven on the local clock.
`timescale 1ns/1ps
`include "oblp_defs.svh"

module oblp_buf_mem (
  input wire logic i_mclk,
  oblp_mem_if.mem mif
);

  oblp_pkg::oblp_entry_t mem_r [0:(1 << `OB_BUF_AW) - 1];
  oblp_pkg::oblp_entry_t rdata_r;

  always_ff @(posedge i_mclk)
  begin
    if (mif.we)
    begin
      mem_r[mif.waddr] <= mif.wdata;
    end
  end

  always_ff @(posedge i_mclk)
  begin
    if (mif.re)
    begin
      rdata_r <= mem_r[mif.raddr];
    end
  end

  assign mif.rdata = rdata_r;

endmodule

// *** hdl/oblp_port.sv ***
// Outbound local packet port: DDR lane capture, framing, checks and readies.
// Assumes the forwarded clock is far slower than i_mclk and is sampled by it.
//
// Strobed register access and the register offsets were decided locally.
`timescale 1ns/1ps
`include "oblp_defs.svh"

module oblp_port (
  input wire logic i_mclk,
  input wire logic i_nrst,
  input wire logic i_outbound_forwarded_clock,
  input wire logic [15:0] i_outbound_lane_data,
  input wire logic i_outbound_packet_frame,
  input wire logic i_outbound_word_valid,
  input wire logic i_outbound_bad_end_flag,
  output logic o_outbound_buffer_ready,
  output logic [1:0] o_wr_ready,
  output logic [1:0] o_cpl_ready,
  output logic o_outbound_error,
  output logic [31:0] o_pkt_data,
  output logic o_pkt_valid,
  output logic o_pkt_last,
  output logic o_pkt_bad,
  input wire logic i_pkt_ready,
  input wire logic [7:0] i_reg_addr,
  input wire logic [31:0] i_reg_wdata,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  output logic [31:0] o_reg_rdata
);

  // Words in a packet per its header, with a zero length read as the maximum.
  function automatic logic [10:0] exp_words(input logic [31:0] hdr);
    logic [10:0] len;
    len = (hdr[`OB_HDR_LEN] == 10'h000) ? `OB_LEN_MAX : {1'b0, hdr[`OB_HDR_LEN]};
    unique case (hdr[`OB_HDR_TYPE])
      `OB_TYPE_RD32: exp_words = 11'h002;
      `OB_TYPE_RD64: exp_words = 11'h003;
      `OB_TYPE_WR32: exp_words = 11'(len + 11'h002);
      `OB_TYPE_WR64: exp_words = 11'(len + 11'h003);
      `OB_TYPE_CPL: exp_words = 11'h002;
      `OB_TYPE_CPLD: exp_words = 11'(len + 11'h001);
      default: exp_words = 11'h002;
    endcase
  endfunction

  function automatic logic hit(input logic [7:0] addr, input logic [7:0] off);
    hit = (addr == off);
  endfunction

  oblp_mem_if mif ();

  oblp_buf_mem u_mem (
    .i_mclk(i_mclk),
    .mif(mif.mem)
  );

  logic [19:0] sync1_r;
  logic [19:0] sync2_r;
  logic ck_d_r;
  logic [2:0] cap_cnt_r;
  logic cap_rise_r;
  logic [15:0] lo_data_r;
  logic [2:0] lo_flags_r;
  logic w_stb_r;
  logic [31:0] w_data_r;
  logic w_frame_r;
  logic w_bad_r;
  logic cap_pulse;
  logic cap_lo;
  logic cap_hi;

  always_ff @(posedge i_mclk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      sync1_r <= 20'h00000;
      sync2_r <= 20'h00000;
      ck_d_r <= 1'b0;
    end
    else
    begin
      sync1_r <= {i_outbound_forwarded_clock, i_outbound_bad_end_flag,
                  i_outbound_word_valid, i_outbound_packet_frame, i_outbound_lane_data};
      sync2_r <= sync1_r;
      ck_d_r <= sync2_r[19];
    end
  end

  // DDR edge capture
  // Each edge is sampled a quarter period late, in the middle of the data eye.
  always_ff @(posedge i_mclk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      cap_cnt_r <= 3'h0;
      cap_rise_r <= 1'b0;
    end
    else if (sync2_r[19] != ck_d_r)
    begin
      cap_cnt_r <= 3'(`OB_CAP_DELAY_CYC);
      cap_rise_r <= sync2_r[19];
    end
    else if (cap_cnt_r != 3'h0)
    begin
      cap_cnt_r <= cap_cnt_r - 3'h1;
    end
  end

  assign cap_pulse = (cap_cnt_r == 3'h1);
  assign cap_lo = cap_pulse & cap_rise_r;
  assign cap_hi = cap_pulse & ~cap_rise_r;

  // flags per word
  // Frame, valid and bad-end are taken with the low half and cover the whole word.
  always_ff @(posedge i_mclk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      lo_data_r <= 16'h0000;
      lo_flags_r <= 3'h0;
    end
    else if (cap_lo)
    begin
      lo_data_r <= sync2_r[15:0];
      lo_flags_r <= sync2_r[18:16];
    end
  end

  always_ff @(posedge i_mclk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      w_stb_r <= 1'b0;
      w_data_r <= 32'h00000000;
      w_frame_r <= 1'b0;
      w_bad_r <= 1'b0;
    end
    else
    begin
      w_stb_r <= cap_hi & lo_flags_r[1];
      if (cap_hi)
      begin
        w_data_r <= {sync2_r[15:0], lo_data_r};
        w_frame_r <= lo_flags_r[0];
        w_bad_r <= lo_flags_r[2];
      end
    end
  end

  oblp_pkg::oblp_pstate_t st_r;
  oblp_pkg::oblp_pstate_t st_nxt;
  logic [10:0] cnt_r;
  logic [10:0] exp_r;
  logic pkt_bad_r;
  logic [31:0] hdr_r;
  logic [31:0] addr_r;
  logic [31:0] pkts_r;
  logic [`OB_BUF_AW:0] wptr_r;
  logic [`OB_BUF_AW:0] rptr_r;
  logic [`OB_BUF_AW:0] level;
  logic full;
  logic [10:0] cnt_inc;
  logic hdr_malf;
  logic len_bad;
  logic mem_we;
  oblp_pkg::oblp_entry_t entry;
  logic [4:0] st_set;

  assign level = wptr_r - rptr_r;
  assign full = (level == `OB_BUF_DEPTH);
  assign cnt_inc = cnt_r + 11'h001;

  // single word carries no last enables
  always_comb
  begin
    hdr_malf = (w_data_r[`OB_HDR_TYPE] > `OB_TYPE_CPLD);
    if ((w_data_r[`OB_HDR_TYPE] <= `OB_TYPE_WR64) && (w_data_r[`OB_HDR_LEN] == 10'h001)
        && (w_data_r[`OB_HDR_LBE] != 4'h0))
    begin
      hdr_malf = 1'b1;
    end
  end

  assign len_bad = w_frame_r ? (cnt_inc >= exp_r) : (cnt_inc != exp_r);

  always_comb
  begin
    st_nxt = st_r;
    mem_we = 1'b0;
    entry.eop = 1'b0;
    entry.bad = 1'b0;
    entry.data = w_data_r;
    st_set = 5'h00;
    unique case (st_r)
      oblp_pkg::OBLP_P_IDLE:
      begin
        if (w_stb_r && w_frame_r)
        begin
          st_set[`OB_ST_MALF] = hdr_malf;
          if (w_data_r[`OB_HDR_TYPE] == `OB_TYPE_CPL || w_data_r[`OB_HDR_TYPE] == `OB_TYPE_CPLD)
          begin
            st_set[`OB_ST_CPLERR] = (w_data_r[`OB_HDR_STAT] != `OB_STAT_OK);
          end
          if (full)
          begin
            st_set[`OB_ST_OVFL] = 1'b1;
            st_nxt = oblp_pkg::OBLP_P_DROP;
          end
          else
          begin
            mem_we = 1'b1;
            st_nxt = oblp_pkg::OBLP_P_BODY;
          end
        end
        else if (w_stb_r)
        begin
          st_set[`OB_ST_UNEXP] = 1'b1;
        end
      end
      oblp_pkg::OBLP_P_BODY:
      begin
        if (w_stb_r)
        begin
          st_set[`OB_ST_MALF] = len_bad;
          st_set[`OB_ST_BADEND] = ~w_frame_r & w_bad_r;
          if (full)
          begin
            st_set[`OB_ST_OVFL] = 1'b1;
            st_nxt = w_frame_r ? oblp_pkg::OBLP_P_DROP : oblp_pkg::OBLP_P_IDLE;
          end
          else
          begin
            mem_we = 1'b1;
            entry.eop = ~w_frame_r;
            entry.bad = pkt_bad_r | len_bad | (~w_frame_r & w_bad_r);
            st_nxt = w_frame_r ? oblp_pkg::OBLP_P_BODY : oblp_pkg::OBLP_P_IDLE;
          end
        end
      end
      oblp_pkg::OBLP_P_DROP:
      begin
        if (w_stb_r && !w_frame_r)
        begin
          st_nxt = oblp_pkg::OBLP_P_IDLE;
        end
      end
      default:
      begin
        st_nxt = oblp_pkg::OBLP_P_IDLE;
      end
    endcase
  end

  // posted writes and split reads share one framing path
  // completion without data is header plus one word
  always_ff @(posedge i_mclk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      st_r <= oblp_pkg::OBLP_P_IDLE;
      cnt_r <= 11'h000;
      exp_r <= 11'h000;
      pkt_bad_r <= 1'b0;
      hdr_r <= 32'h00000000;
      addr_r <= 32'h00000000;
    end
    else
    begin
      st_r <= st_nxt;
      if (w_stb_r && st_r == oblp_pkg::OBLP_P_IDLE && w_frame_r)
      begin
        cnt_r <= 11'h001;
        exp_r <= exp_words(w_data_r);
        pkt_bad_r <= hdr_malf;
        hdr_r <= w_data_r;
      end
      else if (w_stb_r && st_r == oblp_pkg::OBLP_P_BODY)
      begin
        cnt_r <= cnt_inc;
        pkt_bad_r <= pkt_bad_r | len_bad;
        if ((cnt_r == 11'h001 && (hdr_r[`OB_HDR_TYPE] == `OB_TYPE_RD32
             || hdr_r[`OB_HDR_TYPE] == `OB_TYPE_WR32))
            || (cnt_r == 11'h002 && (hdr_r[`OB_HDR_TYPE] == `OB_TYPE_RD64
             || hdr_r[`OB_HDR_TYPE] == `OB_TYPE_WR64)))
        begin
          addr_r <= w_data_r & `OB_ADDR_MASK;
        end
      end
    end
  end

  logic rd_pend_r;
  logic out_valid_r;
  logic issue;

  assign issue = (level != 5'h00) & ~rd_pend_r & (~out_valid_r | i_pkt_ready);
  assign mif.we = mem_we;
  assign mif.waddr = wptr_r[`OB_BUF_AW-1:0];
  assign mif.wdata = entry;
  assign mif.re = issue;
  assign mif.raddr = rptr_r[`OB_BUF_AW-1:0];

  always_ff @(posedge i_mclk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      wptr_r <= 5'h00;
      rptr_r <= 5'h00;
      rd_pend_r <= 1'b0;
      out_valid_r <= 1'b0;
      o_pkt_data <= 32'h00000000;
      o_pkt_last <= 1'b0;
      o_pkt_bad <= 1'b0;
      pkts_r <= 32'h00000000;
    end
    else
    begin
      if (mem_we)
      begin
        wptr_r <= wptr_r + 5'h01;
      end
      if (mem_we && entry.eop)
      begin
        pkts_r <= pkts_r + 32'h00000001;
      end
      if (issue)
      begin
        rptr_r <= rptr_r + 5'h01;
      end
      rd_pend_r <= issue;
      if (rd_pend_r)
      begin
        out_valid_r <= 1'b1;
        o_pkt_data <= mif.rdata.data;
        o_pkt_last <= mif.rdata.eop;
        o_pkt_bad <= mif.rdata.bad;
      end
      else if (i_pkt_ready)
      begin
        out_valid_r <= 1'b0;
      end
    end
  end

  assign o_pkt_valid = out_valid_r;

  logic [3:0] ctrl_r;
  logic [4:0] status_r;
  logic [2:0] cpl_busy_r;
  logic space_ok_r;

  // sticky error bits, a new event beats a clear in the same cycle
  always_ff @(posedge i_mclk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      ctrl_r <= `OB_CTRL_RST;
      status_r <= 5'h00;
      o_reg_rdata <= 32'h00000000;
    end
    else
    begin
      if (i_reg_wr && hit(i_reg_addr, `OB_REG_CTRL))
      begin
        ctrl_r <= i_reg_wdata[3:0];
      end
      status_r <= (status_r & ~((i_reg_wr && hit(i_reg_addr, `OB_REG_STATUS))
                  ? i_reg_wdata[4:0] : 5'h00)) | st_set;
      o_reg_rdata <= 32'h00000000;
      if (i_reg_rd)
      begin
        if (hit(i_reg_addr, `OB_REG_CTRL))
          o_reg_rdata <= {28'h0000000, ctrl_r};
        else if (hit(i_reg_addr, `OB_REG_STATUS))
          o_reg_rdata <= {27'h0000000, status_r};
        else if (hit(i_reg_addr, `OB_REG_PKTS))
          o_reg_rdata <= pkts_r;
        else if (hit(i_reg_addr, `OB_REG_HDR))
          o_reg_rdata <= hdr_r;
        else if (hit(i_reg_addr, `OB_REG_ADDR))
          o_reg_rdata <= addr_r;
        else if (hit(i_reg_addr, `OB_REG_LEVEL))
          o_reg_rdata <= {27'h0000000, level};
      end
    end
  end

  // margin covers the far end's three-cycle stop
  always_ff @(posedge i_mclk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      cpl_busy_r <= 3'h0;
      space_ok_r <= 1'b0;
    end
    else
    begin
      if (i_reg_wr || i_reg_rd)
        cpl_busy_r <= 3'(`OB_CPL_HOLD_CYC);
      else if (cpl_busy_r != 3'h0)
        cpl_busy_r <= cpl_busy_r - 3'h1;
      space_ok_r <= (level + 5'(mem_we) < (`OB_BUF_DEPTH - `OB_RDY_MARGIN));
    end
  end

  assign o_outbound_buffer_ready = space_ok_r;
  assign o_outbound_error = status_r[`OB_ST_UNEXP] | status_r[`OB_ST_MALF]
                            | status_r[`OB_ST_OVFL];

  genvar v;
  generate
    for (v = 0; v < 2; v = v + 1)
    begin : g_vc
      assign o_wr_ready[v] = ctrl_r[`OB_CTRL_EN] & space_ok_r
                             & ~ctrl_r[`OB_CTRL_WR_HOLD0 + v];
      assign o_cpl_ready[v] = ctrl_r[`OB_CTRL_EN] & space_ok_r
                              & ~ctrl_r[`OB_CTRL_CPL_HOLD] & (cpl_busy_r == 3'h0);
    end
  endgenerate

  default clocking cb @(posedge i_mclk);
  endclocking
  default disable iff (!i_nrst);

  a_ddr_word_edge: assert property (w_stb_r |-> $past(cap_hi) && $past(lo_flags_r[1]))
    else $error("word strobe without a falling-edge capture of a valid word");
  a_word_valid_gate: assert property (cap_hi && !lo_flags_r[1] |=> !w_stb_r)
    else $error("word taken while valid was low");
  a_buf_ready_room: assert property (level >= 5'h0C |=> !o_outbound_buffer_ready)
    else $error("buffer ready high while nearly full");
  a_cpl_ready_hold: assert property ((i_reg_wr || i_reg_rd) |=> (o_cpl_ready == 2'b00)[*4])
    else $error("completion ready not dropped for the register access");
  a_wr_ready_split: assert property (ctrl_r == 4'h9 && space_ok_r |-> o_wr_ready == 2'b01)
    else $error("write readies not independent per channel");
  a_unexp_error: assert property (w_stb_r && !w_frame_r && st_r == oblp_pkg::OBLP_P_IDLE
    |=> o_outbound_error)
    else $error("unframed word did not raise the error output");
  a_reserved_type: assert property (w_stb_r && w_frame_r && st_r == oblp_pkg::OBLP_P_IDLE
    && w_data_r[27:24] > 4'h5 |=> status_r[1])
    else $error("reserved header type not flagged malformed");
  a_bad_end_mark: assert property (mem_we && st_r == oblp_pkg::OBLP_P_BODY && !w_frame_r
    && w_bad_r |-> entry.eop && entry.bad)
    else $error("bad-end packet not marked bad");
  a_eop_frame_low: assert property (mem_we && entry.eop |=> st_r == oblp_pkg::OBLP_P_IDLE)
    else $error("packet still open after its last word was written");
  a_len_zero_max: assert property (w_stb_r && w_frame_r && st_r == oblp_pkg::OBLP_P_IDLE
    && w_data_r[27:24] == 4'h2 && w_data_r[9:0] == 10'h000 |=> exp_r == 11'h402)
    else $error("zero length not read as 1024 words");

endmodule

// *** bench/oblp_fpga_model.sv ***
// Behavioural far-end logic that sends outbound packets on the DDR lane.
// Assumes the device samples the lane and its flags from its own local clock.
`timescale 1ns/1ps

module oblp_fpga_model (
  input wire logic i_mclk,
  input wire logic i_ready,
  input wire logic [1:0] i_wr_ready,
  input wire logic [1:0] i_cpl_ready,
  output logic o_clk,
  output logic [15:0] o_data,
  output logic o_frame,
  output logic o_valid,
  output logic o_bad
);
  initial
  begin
    o_clk = 1'b0;
    o_data = 16'h0000;
    o_frame = 1'b0;
    o_valid = 1'b0;
    o_bad = 1'b0;
  end

  task automatic beat(input logic [31:0] w, input logic fr, input logic vl, input logic bd);
    o_data = w[15:0];
    o_frame = fr;
    o_valid = vl;
    o_bad = bd;
    o_clk = 1'b1;
    #200;
    o_data = w[31:16];
    o_clk = 1'b0;
    #200;
  endtask

  // The clock stands still between frames and the lane shows no stale word.
  task automatic idle();
    o_frame = 1'b0;
    o_valid = 1'b0;
    o_bad = 1'b0;
    o_data = ~o_data;
  endtask

  task automatic send(input logic [31:0] w[$], input logic bd, input logic obey);
    @(posedge i_mclk);
    while (obey && ((w[0][27:25] == 3'h2 && i_cpl_ready[w[0][12]] !== 1'b1) ||
           (w[0][27:25] == 3'h1 && i_wr_ready[w[0][12]] !== 1'b1)))
      @(posedge i_mclk);
    #7;
    foreach (w[i])
    begin
      while (obey && i_ready !== 1'b1)
        beat(~w[i], 1'b1, 1'b0, 1'b0);
      beat(w[i], i != w.size() - 1, 1'b1, bd && i == w.size() - 1);
    end
    idle();
  endtask

  task automatic loose(input logic [31:0] w);
    @(posedge i_mclk);
    #7;
    beat(w, 1'b0, 1'b1, 1'b0);
    idle();
  endtask
endmodule

// *** bench/oblp_port_tb.sv ***
// Self-checking bench of the outbound local packet port.
// Assumes the far-end model oblp_fpga_model and the constants of oblp_defs.svh.
`timescale 1ns/1ps
`include "oblp_defs.svh"
`define CHK(got, exp) \
  begin \
    n_compared++; \
    if ((got) !== (exp)) \
    begin \
      err_count++; \
      $display("[FAIL] t=%0t got=%0h exp=%0h", $time, (got), (exp)); \
    end \
  end

module oblp_port_tb;
  logic i_mclk, i_nrst, fclk, frame, valid, bad, i_pkt_ready, i_reg_wr, i_reg_rd;
  logic [15:0] lane;
  logic [7:0] i_reg_addr;
  logic [31:0] i_reg_wdata, o_reg_rdata, o_pkt_data, rd, last_hdr, last_addr;
  logic o_outbound_buffer_ready, o_outbound_error, o_pkt_valid, o_pkt_last, o_pkt_bad;
  logic [1:0] o_wr_ready, o_cpl_ready;
  logic chk = 1'b0, stall = 1'b0, rnd_en = 1'b0, saw_low = 1'b0;
  logic [33:0] exp_q[$];
  int err_count = 0, n_compared = 0, k;

  oblp_port i_dut (.i_mclk(i_mclk), .i_nrst(i_nrst), .i_outbound_forwarded_clock(fclk),
    .i_outbound_lane_data(lane), .i_outbound_packet_frame(frame),
    .i_outbound_word_valid(valid), .i_outbound_bad_end_flag(bad),
    .o_outbound_buffer_ready(o_outbound_buffer_ready), .o_wr_ready(o_wr_ready),
    .o_cpl_ready(o_cpl_ready), .o_outbound_error(o_outbound_error), .o_pkt_data(o_pkt_data),
    .o_pkt_valid(o_pkt_valid), .o_pkt_last(o_pkt_last), .o_pkt_bad(o_pkt_bad),
    .i_pkt_ready(i_pkt_ready), .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata),
    .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd), .o_reg_rdata(o_reg_rdata));

  oblp_fpga_model i_far (.i_mclk(i_mclk), .i_ready(o_outbound_buffer_ready),
    .i_wr_ready(o_wr_ready), .i_cpl_ready(o_cpl_ready), .o_clk(fclk), .o_data(lane),
    .o_frame(frame), .o_valid(valid), .o_bad(bad));

  initial
  begin
    i_mclk = 1'b0;
    forever #25 i_mclk = ~i_mclk;
  end

  always @(posedge i_mclk)
    i_pkt_ready <= rnd_en && !stall && ($urandom % 4 != 0);

  always @(posedge i_mclk)
    if (stall && o_outbound_buffer_ready === 1'b0)
      saw_low <= 1'b1;

  always @(posedge i_mclk)
    if (chk && i_nrst === 1'b1 && o_pkt_valid === 1'b1 && i_pkt_ready === 1'b1)
    begin
      if (exp_q.size() == 0)
        `CHK(o_pkt_valid, 1'b0)
      else
        `CHK({o_pkt_bad & o_pkt_last, o_pkt_last, o_pkt_data}, exp_q.pop_front())
    end

  task automatic report_and_stop();
    if (err_count == 0 && n_compared > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_mclk);
    i_reg_addr <= a;
    i_reg_wdata <= d;
    i_reg_wr <= 1'b1;
    @(posedge i_mclk);
    i_reg_wr <= 1'b0;
  endtask

  task automatic reg_rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge i_mclk);
    i_reg_addr <= a;
    i_reg_rd <= 1'b1;
    @(posedge i_mclk);
    i_reg_rd <= 1'b0;
    @(negedge i_mclk);
    d = o_reg_rdata;
  endtask

  // Header with random class and channel; status shares the low enable bits.
  function automatic logic [31:0] mk_hdr(input logic [3:0] ty, input logic [9:0] len,
                                         input logic [1:0] st);
    logic [31:0] h;
    h = {1'b0, 3'($urandom), ty, 8'h00, 3'h0, 1'($urandom), 2'h0, len};
    if (ty < 4'h4)
      h[23:16] = (len == 10'h001) ? 8'h0F : 8'hFF;
    else
      h[17:16] = st;
    return h;
  endfunction

  task automatic run_pkt(input logic [3:0] ty, input logic [9:0] len, input logic [1:0] st,
                         input logic bd, input logic obey);
    logic [31:0] w[$];
    last_hdr = mk_hdr(ty, len, st);
    w.push_back(last_hdr);
    if (ty != `OB_TYPE_CPLD)
      w.push_back($urandom);
    if (ty == `OB_TYPE_RD64 || ty == `OB_TYPE_WR64)
      w.push_back($urandom);
    last_addr = w[w.size() - 1];
    if (ty == `OB_TYPE_WR32 || ty == `OB_TYPE_WR64 || ty == `OB_TYPE_CPLD)
      repeat (len) w.push_back($urandom);
    if (chk)
      foreach (w[i])
        exp_q.push_back({bd && i == w.size() - 1, i == w.size() - 1, w[i]});
    i_far.send(w, bd, obey);
  endtask

  task automatic drain();
    for (int n = 0; n < 4000 && exp_q.size() != 0; n++)
      @(posedge i_mclk);
    `CHK(exp_q.size(), 0)
    repeat (4) @(posedge i_mclk);
  endtask

  initial
  begin
    #1000000;
    err_count++;
    report_and_stop();
  end

  initial
  begin
    k = $urandom(32'h6879);
    i_nrst = 1'b0;
    i_reg_addr = 8'h00;
    i_reg_wdata = 32'h00000000;
    i_reg_wr = 1'b0;
    i_reg_rd = 1'b0;
    repeat (5) @(posedge i_mclk);
    @(negedge i_mclk);
    `CHK({o_outbound_buffer_ready, o_wr_ready, o_cpl_ready, o_reg_rdata}, 37'h0)
    @(posedge i_mclk);
    i_nrst <= 1'b1;
    repeat (3) @(negedge i_mclk);
    `CHK({o_outbound_buffer_ready, o_wr_ready, o_cpl_ready, o_outbound_error}, 6'h3E)
    reg_rd(`OB_REG_CTRL, rd);
    `CHK(rd, 32'h00000001)
    rnd_en = 1'b1;
    chk = 1'b1;
    for (k = 0; k < 24; k++)
      run_pkt(4'($urandom % 6), 10'($urandom % 4 + 1), 2'h0, 1'b0, 1'b1);
    drain();
    reg_rd(`OB_REG_PKTS, rd);
    `CHK({o_outbound_error, rd}, 33'h000000018)
    run_pkt(`OB_TYPE_WR32, 10'h002, 2'h0, 1'b0, 1'b1);
    drain();
    reg_rd(`OB_REG_ADDR, rd);
    `CHK(rd, last_addr & `OB_ADDR_MASK)
    reg_rd(`OB_REG_HDR, rd);
    `CHK(rd, last_hdr)
    for (k = 0; k < 4; k++)
    begin
      reg_wr(`OB_REG_STATUS, 32'h0000001F);
      run_pkt(`OB_TYPE_CPLD, 10'h001, 2'(k), 1'b0, 1'b1);
      drain();
      reg_rd(`OB_REG_STATUS, rd);
      `CHK(rd[4:0], (k == 0) ? 5'h00 : 5'h10)
    end
    reg_wr(`OB_REG_STATUS, 32'h0000001F);
    run_pkt(`OB_TYPE_WR32, 10'h003, 2'h0, 1'b1, 1'b1);
    drain();
    reg_rd(`OB_REG_STATUS, rd);
    `CHK({o_outbound_error, rd[4:0]}, 6'h08)
    chk = 1'b0;
    for (k = 6; k < 16; k++)
    begin
      run_pkt(4'(k), 10'h001, 2'h0, 1'b0, 1'b1);
      repeat (40) @(posedge i_mclk);
      reg_rd(`OB_REG_STATUS, rd);
      `CHK({o_outbound_error, rd[1]}, 2'h3)
      reg_wr(`OB_REG_STATUS, 32'h0000001F);
      @(negedge i_mclk);
      `CHK(o_outbound_error, 1'b0)
    end
    run_pkt(`OB_TYPE_WR32, 10'h000, 2'h0, 1'b0, 1'b1);
    repeat (40) @(posedge i_mclk);
    reg_rd(`OB_REG_STATUS, rd);
    `CHK({o_outbound_error, rd[1]}, 2'h3)
    reg_wr(`OB_REG_STATUS, 32'h0000001F);
    i_far.loose($urandom);
    repeat (40) @(posedge i_mclk);
    reg_rd(`OB_REG_STATUS, rd);
    `CHK({o_outbound_error, rd[0]}, 2'h3)
    reg_wr(`OB_REG_STATUS, 32'h0000001F);
    chk = 1'b1;
    stall <= 1'b1;
    fork
      run_pkt(`OB_TYPE_WR32, 10'h010, 2'h0, 1'b0, 1'b1);
      begin
        repeat (400) @(posedge i_mclk);
        stall <= 1'b0;
      end
    join
    drain();
    reg_rd(`OB_REG_STATUS, rd);
    `CHK({saw_low, o_outbound_error, rd[2]}, 3'h4)
    chk = 1'b0;
    stall <= 1'b1;
    run_pkt(`OB_TYPE_WR32, 10'h016, 2'h0, 1'b0, 1'b0);
    reg_rd(`OB_REG_STATUS, rd);
    `CHK({o_outbound_error, rd[2]}, 2'h3)
    stall <= 1'b0;
    repeat (100) @(negedge i_mclk);
    `CHK(o_outbound_buffer_ready, 1'b1)
    reg_wr(`OB_REG_STATUS, 32'h0000001F);
    reg_rd(8'h40, rd);
    `CHK(rd, 32'h00000000)
    for (k = 0; k < 5; k++)
    begin
      `CHK(o_cpl_ready, (k < 4) ? 2'h0 : 2'h3)
      @(negedge i_mclk);
    end
    for (k = 0; k < 4; k++)
    begin
      reg_wr(`OB_REG_CTRL, {28'h0000000, 2'(k), 2'h1});
      repeat (6) @(negedge i_mclk);
      `CHK({o_wr_ready, o_cpl_ready}, {~2'(k), 2'h3})
    end
    reg_wr(`OB_REG_CTRL, 32'h00000003);
    repeat (6) @(negedge i_mclk);
    `CHK({o_wr_ready, o_cpl_ready}, 4'hC)
    reg_wr(`OB_REG_CTRL, 32'h00000001);
    report_and_stop();
  end
endmodule
